// ---- tcmi_pkg.sv ----
// Package with register map, field layout, modes and bus types of the timer compare block.
package tcmi_pkg;
    // Word index of each register; byte address is four times the index.
    localparam logic [7:0] REG_CMP_A = 8'h36;
    localparam logic [7:0] REG_MASK = 8'h39;
    localparam logic [7:0] REG_CMP_B = 8'h3a;
    localparam logic [7:0] REG_FLAGS = 8'h3b;
    localparam logic [7:0] REG_COUNT = 8'h3c;
    localparam logic [7:0] REG_CTRL = 8'h3d;
    localparam logic [7:0] REG_IRQ_ST = 8'h3e;
    localparam logic [7:0] REG_IRQ_MASK = 8'h3f;
    // Flag and mask bit positions.
    localparam int BIT_OVF = 0;
    localparam int BIT_MATCH_A = 1;
    localparam int BIT_MATCH_B = 2;
    localparam int NUM_FLAGS = 3;
    // Control register fields.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RUN = 3;
    localparam int CTRL_FORCE_A = 4;
    localparam int CTRL_FORCE_B = 5;
    // Count limits and reset values.
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] RESET_FLAGS = 3'h0;
    localparam logic [2:0] RESET_MODE = 3'h0;
    localparam int WAIT_CYCLES = 1;

    // Waveform generation modes.
    typedef enum logic [2:0] {
        TCMI_NORMAL = 3'h0,
        TCMI_PC_FIXED = 3'h1,
        TCMI_CTC = 3'h2,
        TCMI_FAST_FIXED = 3'h3,
        TCMI_RSVD4 = 3'h4,
        TCMI_PC_CMP = 3'h5,
        TCMI_RSVD6 = 3'h6,
        TCMI_FAST_CMP = 3'h7
    } tcmi_mode_e;

    // Avalon-MM request as seen by the slave.
    typedef struct packed {
        logic read;
        logic write;
        logic [9:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } tcmi_req_s;

    // Per-cycle timer events.
    typedef struct packed {
        logic match_b;
        logic match_a;
        logic ovf;
    } tcmi_evt_s;
endpackage

// ---- tcmi_flag.sv ----
// One sticky interrupt flag with hardware set, vector clear and write-one clear.
`timescale 1ns/1ps
module tcmi_flag (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic set_evt,
    input wire logic vec_clr,
    input wire logic sw_clr,
    output logic flag
);
    // Set wins over either clear so an event in the clearing cycle is kept.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1;
        end else if (vec_clr || sw_clr) begin
            flag <= 1'b0;
        end
    end

    AST_SET_WINS: assert property (@(posedge mclk) disable iff (!rstn)
        set_evt |=> flag) else $error("flag lost a set event");
endmodule

// ---- tcmi_counter.sv ----
// Eight-bit counter with mode dependent top, direction and overflow point.
`timescale 1ns/1ps
module tcmi_counter (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [2:0] mode,
    input wire logic [7:0] top_cmp,
    input wire logic load,
    input wire logic [7:0] load_val,
    output logic [7:0] count_ff,
    output logic down_ff,
    output logic ovf_evt,
    output logic tick
);
    logic [7:0] top;
    logic fixed_top;
    logic phase_mode;
    logic [7:0] nxt_count;
    logic nxt_down;

    // Top is either the fixed maximum or compare A, chosen by mode.
    assign fixed_top = (mode == tcmi_pkg::TCMI_NORMAL) || (mode == tcmi_pkg::TCMI_PC_FIXED)
                       || (mode == tcmi_pkg::TCMI_FAST_FIXED);
    assign top = fixed_top ? tcmi_pkg::COUNT_MAX : top_cmp;
    assign phase_mode = (mode == tcmi_pkg::TCMI_PC_FIXED) || (mode == tcmi_pkg::TCMI_PC_CMP);
    assign tick = run && !load;

    // Next count and overflow point per mode.
    always_comb begin
        nxt_count = count_ff;
        nxt_down = down_ff;
        ovf_evt = 1'b0;
        if (tick) begin
            unique case (tcmi_pkg::tcmi_mode_e'(mode))
                tcmi_pkg::TCMI_PC_FIXED, tcmi_pkg::TCMI_PC_CMP: begin
                    if (!down_ff && count_ff >= top) begin
                        nxt_down = 1'b1;
                        nxt_count = count_ff - 8'h01;
                    end else if (down_ff && count_ff == tcmi_pkg::COUNT_BOTTOM) begin
                        nxt_down = 1'b0;
                        nxt_count = count_ff + 8'h01;
                        ovf_evt = 1'b1;
                    end else begin
                        nxt_count = down_ff ? count_ff - 8'h01 : count_ff + 8'h01;
                    end
                end
                tcmi_pkg::TCMI_CTC: begin
                    nxt_down = 1'b0;
                    nxt_count = (count_ff == top) ? tcmi_pkg::COUNT_BOTTOM : count_ff + 8'h01;
                    ovf_evt = (count_ff == tcmi_pkg::COUNT_MAX);
                end
                tcmi_pkg::TCMI_FAST_CMP: begin
                    nxt_down = 1'b0;
                    nxt_count = (count_ff >= top) ? tcmi_pkg::COUNT_BOTTOM : count_ff + 8'h01;
                    ovf_evt = (count_ff == top);
                end
                default: begin
                    nxt_down = 1'b0;
                    nxt_count = count_ff + 8'h01;
                    ovf_evt = (count_ff == tcmi_pkg::COUNT_MAX);
                end
            endcase
        end
        if (load) begin
            nxt_count = load_val;
        end
    end

    // A software load overrides counting.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_ff <= tcmi_pkg::RESET_BYTE;
            down_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            down_ff <= phase_mode ? nxt_down : 1'b0;
        end
    end

    AST_PC_BOTTOM_OVF: assert property (@(posedge mclk) disable iff (!rstn)
        (tick && phase_mode && down_ff && count_ff == 8'h00) |-> ovf_evt)
        else $error("phase correct overflow missed at bottom");
endmodule

// ---- tcmi_top.sv ----
// Top of the timer compare and interrupt block with its Avalon-MM register slave.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module tcmi_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cpu_global_ie,
    input wire logic [2:0] vector_ack,
    output logic [2:0] timer_irq_req,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic irq
);
    tcmi_pkg::tcmi_req_s req;
    logic [7:0] compare_a_value_ff;
    logic [7:0] compare_b_value_ff;
    logic [2:0] timer_interrupt_mask_ff;
    logic [2:0] timer_interrupt_flags;
    logic [2:0] wave_mode_select_ff;
    logic run_ff;
    logic [2:0] irq_status_ff;
    logic [2:0] irq_mask_ff;
    logic [31:0] readdata_ff;
    logic waitrequest_ff;
    logic [2:0] timer_irq_req_ff;
    logic wave_a_ff;
    logic wave_b_ff;
    logic irq_ff;
    logic suppress_ff;
    logic [7:0] counter_value;
    logic ovf_evt;
    logic tick;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] reg_idx;
    logic lane0;
    logic [7:0] wbyte;
    logic cnt_load;
    logic force_a;
    logic force_b;
    logic match_a_hit;
    logic match_b_hit;
    tcmi_pkg::tcmi_evt_s evt;
    logic [2:0] sw_clr;
    logic [31:0] nxt_readdata;

    assign req = '{read: avs_read, write: avs_write, address: avs_address,
                   byteenable: avs_byteenable, writedata: avs_writedata};
    assign reg_idx = req.address[9:2];
    assign lane0 = req.byteenable[0];
    assign wbyte = req.writedata[7:0];
    // A request is taken at the edge where waitrequest is low.
    assign acc = (req.read || req.write) && !waitrequest_ff;
    assign wr_acc = acc && req.write && lane0;
    assign rd_acc = acc && req.read;

    // Waitrequest drops for one cycle after a request appears, then rises again.
    // The fixed single wait state keeps read data registered without a bypass.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            waitrequest_ff <= 1'b1;
        end else if ((req.read || req.write) && waitrequest_ff) begin
            waitrequest_ff <= 1'b0;
        end else begin
            waitrequest_ff <= 1'b1;
        end
    end

    // Compare and mask registers.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            compare_a_value_ff <= tcmi_pkg::RESET_BYTE;
            compare_b_value_ff <= tcmi_pkg::RESET_BYTE;
            timer_interrupt_mask_ff <= tcmi_pkg::RESET_FLAGS;
            irq_mask_ff <= tcmi_pkg::RESET_FLAGS;
        end else if (wr_acc) begin
            if (reg_idx == tcmi_pkg::REG_CMP_A) begin
                compare_a_value_ff <= wbyte;
            end
            if (reg_idx == tcmi_pkg::REG_CMP_B) begin
                compare_b_value_ff <= wbyte;
            end
            if (reg_idx == tcmi_pkg::REG_MASK) begin
                timer_interrupt_mask_ff <= wbyte[2:0];
            end
            if (reg_idx == tcmi_pkg::REG_IRQ_MASK) begin
                irq_mask_ff <= wbyte[2:0];
            end
        end
    end

    // Control register: mode, run enable; force bits are strobes only.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wave_mode_select_ff <= tcmi_pkg::RESET_MODE;
            run_ff <= 1'b0;
        end else if (wr_acc && reg_idx == tcmi_pkg::REG_CTRL) begin
            wave_mode_select_ff <= wbyte[tcmi_pkg::CTRL_MODE_LSB +: 3];
            run_ff <= wbyte[tcmi_pkg::CTRL_RUN];
        end
    end

    assign cnt_load = wr_acc && reg_idx == tcmi_pkg::REG_COUNT;
    // Forcing only works in the non-PWM modes.
    // A forced strobe only reaches the pins, never the flags or the counter clear.
    assign force_a = wr_acc && reg_idx == tcmi_pkg::REG_CTRL && wbyte[tcmi_pkg::CTRL_FORCE_A]
                     && !wave_mode_select_ff[0];
    assign force_b = wr_acc && reg_idx == tcmi_pkg::REG_CTRL && wbyte[tcmi_pkg::CTRL_FORCE_B]
                     && !wave_mode_select_ff[0];

    tcmi_counter u_counter (
        .mclk(mclk),
        .rstn(rstn),
        .run(run_ff),
        .mode(wave_mode_select_ff),
        .top_cmp(compare_a_value_ff),
        .load(cnt_load),
        .load_val(wbyte),
        .count_ff(counter_value),
        .down_ff(),
        .ovf_evt(ovf_evt),
        .tick(tick)
    );

    // A counter write blocks matches until the next timer clock has passed.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            suppress_ff <= 1'b0;
        end else if (cnt_load) begin
            suppress_ff <= 1'b1;
        end else if (tick) begin
            suppress_ff <= 1'b0;
        end
    end

    // Compare logic; forced strobes never reach the events.
    assign match_a_hit = run_ff && !suppress_ff && !cnt_load
                         && (counter_value == compare_a_value_ff);
    assign match_b_hit = run_ff && !suppress_ff && !cnt_load
                         && (counter_value == compare_b_value_ff);
    // The event word has a single driver so no field is written from two places.
    assign evt = '{match_b: match_b_hit, match_a: match_a_hit, ovf: ovf_evt};

    assign sw_clr = (wr_acc && reg_idx == tcmi_pkg::REG_FLAGS) ? wbyte[2:0] : 3'h0;

    // One sticky flag per interrupt source.
    genvar g;
    generate
        for (g = 0; g < tcmi_pkg::NUM_FLAGS; g++) begin : g_flag
            tcmi_flag u_flag (
                .mclk(mclk),
                .rstn(rstn),
                .set_evt(evt[g]),
                .vec_clr(vector_ack[g]),
                .sw_clr(sw_clr[g]),
                .flag(timer_interrupt_flags[g])
            );
        end
    endgenerate

    // Wave pins toggle on real or forced matches.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wave_a_ff <= 1'b0;
            wave_b_ff <= 1'b0;
        end else begin
            if (evt.match_a || force_a) begin
                wave_a_ff <= !wave_a_ff;
            end
            if (evt.match_b || force_b) begin
                wave_b_ff <= !wave_b_ff;
            end
        end
    end

    // Vector requests to the CPU, gated by the global enable.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            timer_irq_req_ff <= 3'h0;
        end else begin
            timer_irq_req_ff[tcmi_pkg::BIT_MATCH_B] <= cpu_global_ie
                && timer_interrupt_mask_ff[2] && timer_interrupt_flags[2];
            timer_irq_req_ff[tcmi_pkg::BIT_MATCH_A] <= cpu_global_ie
                && timer_interrupt_mask_ff[1] && timer_interrupt_flags[1];
            timer_irq_req_ff[tcmi_pkg::BIT_OVF] <= cpu_global_ie
                && timer_interrupt_mask_ff[0] && timer_interrupt_flags[0];
        end
    end

    // Bus level status: events stick until that register is read; set beats read.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_status_ff <= tcmi_pkg::RESET_FLAGS;
            irq_ff <= 1'b0;
        end else begin
            if (rd_acc && reg_idx == tcmi_pkg::REG_IRQ_ST) begin
                irq_status_ff <= evt;
            end else begin
                irq_status_ff <= irq_status_ff | evt;
            end
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        nxt_readdata = 32'h0000_0000;
        unique case (reg_idx)
            tcmi_pkg::REG_CMP_A: nxt_readdata[7:0] = compare_a_value_ff;
            tcmi_pkg::REG_CMP_B: nxt_readdata[7:0] = compare_b_value_ff;
            tcmi_pkg::REG_MASK: nxt_readdata[2:0] = timer_interrupt_mask_ff;
            tcmi_pkg::REG_FLAGS: nxt_readdata[2:0] = timer_interrupt_flags;
            tcmi_pkg::REG_COUNT: nxt_readdata[7:0] = counter_value;
            tcmi_pkg::REG_CTRL: nxt_readdata[3:0] = {run_ff, wave_mode_select_ff};
            tcmi_pkg::REG_IRQ_ST: nxt_readdata[2:0] = irq_status_ff;
            tcmi_pkg::REG_IRQ_MASK: nxt_readdata[2:0] = irq_mask_ff;
            default: nxt_readdata = 32'h0000_0000;
        endcase
    end

    // Read data is registered while a read is pending with waitrequest high and held otherwise.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            readdata_ff <= 32'h0000_0000;
        end else if (req.read && waitrequest_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end

    assign avs_readdata = readdata_ff;
    assign avs_waitrequest = waitrequest_ff;
    assign timer_irq_req = timer_irq_req_ff;
    assign wave_out_a = wave_a_ff;
    assign wave_out_b = wave_b_ff;
    assign irq = irq_ff;

    sequence s_match_b;
        timer_interrupt_flags[2] && timer_interrupt_mask_ff[2] && cpu_global_ie;
    endsequence

    AST_REQ_B: assert property (@(posedge mclk) disable iff (!rstn)
        s_match_b |=> timer_irq_req[2]) else $error("match b request missing");
    AST_REQ_A: assert property (@(posedge mclk) disable iff (!rstn)
        !cpu_global_ie |=> !timer_irq_req[1]) else $error("match a request ungated");
    AST_REQ_OVF: assert property (@(posedge mclk) disable iff (!rstn)
        !timer_interrupt_mask_ff[0] |=> !timer_irq_req[0])
        else $error("overflow request unmasked");
    AST_FLAG_B: assert property (@(posedge mclk) disable iff (!rstn)
        (run_ff && !suppress_ff && !cnt_load && counter_value == compare_b_value_ff)
        |=> timer_interrupt_flags[2]) else $error("flag b not set");
    AST_FLAG_A: assert property (@(posedge mclk) disable iff (!rstn)
        evt.match_a |=> timer_interrupt_flags[1] && $changed(wave_out_a))
        else $error("match a effects missing");
    AST_OVF: assert property (@(posedge mclk) disable iff (!rstn)
        evt.ovf |=> timer_interrupt_flags[0]) else $error("overflow flag not set");
    AST_SW_CLR: assert property (@(posedge mclk) disable iff (!rstn)
        (sw_clr[1] && !evt.match_a) |=> !timer_interrupt_flags[1])
        else $error("write one did not clear");
    AST_SUPPRESS: assert property (@(posedge mclk) disable iff (!rstn)
        cnt_load |=> !evt.match_a && !evt.match_b) else $error("match after load");
    AST_RSVD: assert property (@(posedge mclk) disable iff (!rstn)
        (rd_acc && reg_idx == tcmi_pkg::REG_FLAGS) |-> avs_readdata[31:3] == 29'h0)
        else $error("reserved bits not zero");
endmodule

// ---- tcmi_tb.sv ----
// Self-checking testbench of the timer compare and interrupt block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
end
module tb;
    typedef struct {
        logic [2:0] mode;
        logic [7:0] top;
        logic [7:0] load;
        int cyc;
        logic [7:0] flags;
    } tcmi_tbrow_s;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cpu_global_ie = 1'b0;
    logic [2:0] vector_ack = 3'h0;
    logic [2:0] timer_irq_req;
    logic wave_out_a;
    logic wave_out_b;
    logic irq;
    logic wa;
    logic wb;
    int failures = 0;
    int checks_done = 0;
    // Register rows: index, value read back after writing a5.
    logic [7:0] reg_idx[6] = '{8'h36, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h10};
    logic [7:0] reg_exp[6] = '{8'ha5, 8'h05, 8'ha5, 8'h00, 8'ha5, 8'h00};
    // Mode rows: mode, compare A, counter load, run cycles, expected flags.
    tcmi_tbrow_s rows[8] = '{
        '{3'h0, 8'h80, 8'hf0, 40, 8'h01}, '{3'h1, 8'h80, 8'hf0, 20, 8'h00},
        '{3'h1, 8'h80, 8'h10, 600, 8'h07}, '{3'h2, 8'h40, 8'h00, 300, 8'h06},
        '{3'h3, 8'h80, 8'hf0, 40, 8'h01}, '{3'h5, 8'h40, 8'h10, 200, 8'h07},
        '{3'h7, 8'h40, 8'h10, 100, 8'h07}, '{3'h7, 8'h40, 8'h10, 20, 8'h00}};

    tcmi_top u_dut (
        .mclk(mclk),
        .rstn(rstn),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_byteenable(4'hf),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .cpu_global_ie(cpu_global_ie),
        .vector_ack(vector_ack),
        .timer_irq_req(timer_irq_req),
        .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b),
        .irq(irq)
    );

    // Free running system clock.
    initial begin
        forever #10 mclk = ~mclk;
    end

    // One bus transfer; an edge passes first so no signal is assigned twice in a step.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h000000, wd};
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        `CHK("bus answer", 1'b1, n < 50)
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] unused;
        bus(1'b1, idx, d, unused);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] d;
        bus(1'b0, idx, 8'h00, d);
        `CHK(nm, e, d)
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The whole sequence needs far fewer cycles than this bound allows; only a hang reaches it.
    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        $display("wrong value watchdog expected done seen hang");
        test_done();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        // Reset values, then write and read back; reserved mask and flag bits stay zero.
        for (int i = 0; i < 6; i++) begin
            rdchk("reset value", reg_idx[i], 8'h00);
            wr(reg_idx[i], 8'ha5);
            rdchk("register", reg_idx[i], reg_exp[i]);
        end
        wr(tcmi_pkg::REG_CMP_B, 8'h30);
        // Every non-reserved mode: run a span and compare the flags it leaves behind.
        foreach (rows[i]) begin
            wr(tcmi_pkg::REG_CTRL, {5'h00, rows[i].mode});
            wr(tcmi_pkg::REG_CMP_A, rows[i].top);
            wr(tcmi_pkg::REG_COUNT, rows[i].load);
            wr(tcmi_pkg::REG_FLAGS, 8'h07);
            wr(tcmi_pkg::REG_CTRL, {5'h01, rows[i].mode});
            repeat (rows[i].cyc) @(posedge mclk);
            wr(tcmi_pkg::REG_CTRL, {5'h00, rows[i].mode});
            rdchk("mode flags", tcmi_pkg::REG_FLAGS, rows[i].flags);
        end
        // Forced compare in clear-on-match mode moves the pin only.
        wr(tcmi_pkg::REG_CTRL, 8'h02);
        wr(tcmi_pkg::REG_CMP_A, 8'h80);
        wr(tcmi_pkg::REG_COUNT, 8'h10);
        wr(tcmi_pkg::REG_FLAGS, 8'h07);
        wa = wave_out_a;
        // Force while running, then stop after three ticks; a clear would show in the count.
        wr(tcmi_pkg::REG_CTRL, 8'h1a);
        wr(tcmi_pkg::REG_CTRL, 8'h02);
        `CHK("forced pin", ~wa, wave_out_a)
        rdchk("forced flags", tcmi_pkg::REG_FLAGS, 8'h00);
        rdchk("forced count", tcmi_pkg::REG_COUNT, 8'h13);
        // A counter load equal to compare A must not match on the following tick.
        wr(tcmi_pkg::REG_CTRL, 8'h00);
        wr(tcmi_pkg::REG_CMP_A, 8'h20);
        wr(tcmi_pkg::REG_COUNT, 8'h20);
        wr(tcmi_pkg::REG_CTRL, 8'h08);
        wr(tcmi_pkg::REG_CTRL, 8'h00);
        rdchk("load match", tcmi_pkg::REG_FLAGS, 8'h00);
        // Real matches move both pins and set all three flags.
        wa = wave_out_a;
        wb = wave_out_b;
        wr(tcmi_pkg::REG_COUNT, 8'hf0);
        wr(tcmi_pkg::REG_CTRL, 8'h08);
        repeat (80) @(posedge mclk);
        wr(tcmi_pkg::REG_CTRL, 8'h00);
        `CHK("pin a", ~wa, wave_out_a)
        `CHK("pin b", ~wb, wave_out_b)
        rdchk("all flags", tcmi_pkg::REG_FLAGS, 8'h07);
        // Vector requests follow mask, global enable and flags.
        wr(tcmi_pkg::REG_MASK, 8'h07);
        repeat (3) @(posedge mclk);
        `CHK("req gie off", 3'h0, timer_irq_req)
        cpu_global_ie <= 1'b1;
        repeat (3) @(posedge mclk);
        `CHK("req all", 3'h7, timer_irq_req)
        wr(tcmi_pkg::REG_MASK, 8'h05);
        repeat (3) @(posedge mclk);
        `CHK("req masked", 3'h5, timer_irq_req)
        vector_ack <= 3'h1;
        @(posedge mclk);
        vector_ack <= 3'h0;
        repeat (3) @(posedge mclk);
        `CHK("req after vector", 3'h4, timer_irq_req)
        wr(tcmi_pkg::REG_FLAGS, 8'h00);
        rdchk("zero write", tcmi_pkg::REG_FLAGS, 8'h06);
        wr(tcmi_pkg::REG_FLAGS, 8'h04);
        rdchk("one write", tcmi_pkg::REG_FLAGS, 8'h02);
        // Bus interrupt: masked at reset, raised by the mask, dropped by the status read.
        `CHK("irq masked", 1'b0, irq)
        wr(tcmi_pkg::REG_IRQ_MASK, 8'h07);
        repeat (3) @(posedge mclk);
        `CHK("irq raised", 1'b1, irq)
        rdchk("irq status", tcmi_pkg::REG_IRQ_ST, 8'h07);
        repeat (3) @(posedge mclk);
        `CHK("irq cleared", 1'b0, irq)
        // Second reset in mid-run puts outputs and registers back to their reset values.
        wr(tcmi_pkg::REG_CTRL, 8'h08);
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK("reset wait", 1'b1, avs_waitrequest)
        `CHK("reset req", 3'h0, timer_irq_req)
        rstn <= 1'b1;
        rdchk("reset mask", tcmi_pkg::REG_MASK, 8'h00);
        rdchk("reset flags", tcmi_pkg::REG_FLAGS, 8'h00);
        test_done();
    end
endmodule
